// ---- hdl/lblhr_pkg.sv ----
// shared constants for the local bus lane, hold and reset block
package lblhr_pkg;
	localparam int DATA_W = 32;
	localparam int LANES = 4;
	localparam int BURST_W = 2;
	localparam logic [1:0] BURST_ONE = 2'h0;
	localparam logic [1:0] BURST_TWO = 2'h1;
	localparam logic [1:0] BURST_THREE = 2'h2;
	localparam logic [1:0] BURST_FOUR = 2'h3;
	localparam int SIZE_LSB = 0;
	localparam logic [3:0] LANES_IDLE_N = 4'hF;
	localparam int RESET_MIN_DR_CYCLES = 41;
	localparam int RESET_MIN_CYCLES = (RESET_MIN_DR_CYCLES + 1) / 2;
	localparam int BUF_DEPTH = 2;
	typedef enum logic [2:0] {
		BUS_RESET = 3'b000,
		BUS_IDLE = 3'b001,
		BUS_ADDR = 3'b010,
		BUS_DATA = 3'b011,
		BUS_WAIT = 3'b100,
		BUS_HOLD = 3'b101,
		BUS_CHECK = 3'b110
	} lblhr_state_e;
endpackage : lblhr_pkg

// ---- hdl/lblhr_skid_buf.sv ----
// two-entry valid/ready buffer
`timescale 1ns/1ps
`default_nettype none
module lblhr_skid_buf #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 2
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic clkEn,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
	logic [PW:0] count_reg, count_next;
	logic push, pop;

	assign inReady = (count_reg != (PW+1)'(DEPTH));
	assign outValid = (count_reg != '0);
	assign outData = mem_reg[rdPtr_reg];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_comb
	begin
		wrPtr_next = wrPtr_reg;
		rdPtr_next = rdPtr_reg;
		count_next = count_reg;
		if (push)
			wrPtr_next = (wrPtr_reg == PW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
		if (pop)
			rdPtr_next = (rdPtr_reg == PW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
		if (push && !pop)
			count_next = count_reg + 1'b1;
		else if (pop && !push)
			count_next = count_reg - 1'b1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end
		else if (clkEn)
		begin
			wrPtr_reg <= wrPtr_next;
			rdPtr_reg <= rdPtr_next;
			count_reg <= count_next;
			if (push)
				mem_reg[wrPtr_reg] <= inData;
		end
	end
endmodule : lblhr_skid_buf
`default_nettype wire

// ---- hdl/lblhr_bus_ctrl.sv ----
// local bus lane enables, hold hand-over, cache indicator and reset strap
// Notes on behaviour
// - internal clock is double-rate input halved
// - address state carries burst length low bits
// - no ready in data: wait, no strobe
// - four active-low lane enables, lane3 top byte
// - address state shows first word lanes
// - data state shows next word lanes
// - lanes held steady while ready low
// - read lanes mark bytes consumed
// - only contiguous, non-empty lane groups
// - grant: float lines, ack, hold state
// - request drops: ack off, idle/address
// - cacheable indicator driven in address state
// - never cacheable for synchronous accesses
// - cacheable indicator floats when idle
// - error sampled cycle after final ready
// - error input is role strap during reset
// - reset clears, release starts reinit
// - reset ignores inputs, floats, deasserts outputs
`timescale 1ns/1ps
`default_nettype none
module lblhr_bus_ctrl #(
	parameter int DATA_W = lblhr_pkg::DATA_W,
	parameter int LANES = lblhr_pkg::LANES
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic clkEn,
	// transaction request from the core side
	input wire logic reqValid,
	output logic reqReady,
	input wire logic [DATA_W-1:0] reqAddr,
	input wire logic reqWrite,
	input wire logic [1:0] reqBurst,
	input wire logic reqCacheable,
	input wire logic reqSync,
	input wire logic [4*LANES-1:0] reqLanes,
	input wire logic [4*DATA_W-1:0] reqWrData,
	// read words to the core side
	output logic rdValid,
	input wire logic rdReady,
	output logic [DATA_W-1:0] rdData,
	output logic doneValid,
	output logic doneError,
	output logic initRole,
	output logic internalClk,
	// bus pins
	input wire logic [DATA_W-1:0] localAddrDataIn,
	output logic [DATA_W-1:0] localAddrDataOut,
	output logic localAddrDataOe,
	output logic addressStrobeN,
	output logic addressStrobeOe,
	output logic writeNotRead,
	output logic [LANES-1:0] byteLaneEnablesN,
	output logic byteLaneEnablesOe,
	output logic cacheable,
	output logic cacheableOe,
	input wire logic readyN,
	input wire logic holdReq,
	output logic busGrantAck,
	output logic busGrantAckOe,
	input wire logic accessErrorIn
);
	logic [1:0] readySync_reg, holdSync_reg, errSync_reg;
	logic readyIn, holdIn, errIn;
	lblhr_pkg::lblhr_state_e state_reg, state_next;
	logic [DATA_W-1:0] addr_reg, addr_next;
	logic write_reg, write_next, cache_reg, cache_next;
	logic [1:0] burst_reg, burst_next, word_reg, word_next;
	logic [4*LANES-1:0] lanesAll_reg, lanesAll_next;
	logic [4*DATA_W-1:0] wrData_reg, wrData_next;
	logic [LANES-1:0] lanesOut_reg, lanesOut_next;
	logic [DATA_W-1:0] dataOut_reg, dataOut_next;
	logic strobe_reg, strobe_next, grant_reg, grant_next;
	logic error_reg, error_next, done_reg, done_next;
	logic role_reg, role_next, halfClk_reg;
	logic [5:0] rstCnt_reg, rstCnt_next;
	logic bufInValid, bufInReady;
	logic [DATA_W-1:0] bufInData;

	// ready, hold and error pins cross two flops before use; read data goes straight to the buffer
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			readySync_reg <= 2'h0;
			holdSync_reg <= 2'h0;
			errSync_reg <= 2'h0;
		end
		else if (clkEn)
		begin
			readySync_reg <= {readySync_reg[0], ~readyN};
			holdSync_reg <= {holdSync_reg[0], holdReq};
			errSync_reg <= {errSync_reg[0], accessErrorIn};
		end
	end
	assign readyIn = readySync_reg[1];
	assign holdIn = holdSync_reg[1];
	assign errIn = errSync_reg[1];

	// halved clock
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			halfClk_reg <= 1'b0;
		else if (clkEn)
			halfClk_reg <= ~halfClk_reg;
	end
	assign internalClk = halfClk_reg;

	function automatic logic lanesLegal(input logic [LANES-1:0] actv);
		logic seenOn, seenGap, ok;
		seenOn = 1'b0;
		seenGap = 1'b0;
		ok = 1'b1;
		for (int i = 0; i < LANES; i++)
		begin
			if (actv[i] && seenGap)
				ok = 1'b0;
			if (!actv[i] && seenOn)
				seenGap = 1'b1;
			if (actv[i])
				seenOn = 1'b1;
		end
		return ok && seenOn;
	endfunction : lanesLegal

	// illegal lane groups fall back to the full word
	function automatic logic [LANES-1:0] laneSel(input logic [4*LANES-1:0] all,
		input logic [1:0] idx);
		logic [LANES-1:0] a;
		a = all[idx*LANES +: LANES];
		return lanesLegal(a) ? ~a : '0;
	endfunction : laneSel

	assign reqReady = (state_reg == lblhr_pkg::BUS_IDLE) && !holdIn && !srst;

	always_comb
	begin
		state_next = state_reg;
		addr_next = addr_reg;
		write_next = write_reg;
		cache_next = cache_reg;
		burst_next = burst_reg;
		word_next = word_reg;
		lanesAll_next = lanesAll_reg;
		wrData_next = wrData_reg;
		lanesOut_next = lanesOut_reg;
		dataOut_next = dataOut_reg;
		strobe_next = 1'b0;
		grant_next = grant_reg;
		error_next = 1'b0;
		done_next = 1'b0;
		role_next = role_reg;
		rstCnt_next = rstCnt_reg;
		bufInValid = 1'b0;
		bufInData = localAddrDataIn;
		case (state_reg)
			lblhr_pkg::BUS_RESET:
			begin
				// reinit after minimum settle count
				if (rstCnt_reg >= 6'(lblhr_pkg::RESET_MIN_CYCLES))
					state_next = lblhr_pkg::BUS_IDLE;
				else
					rstCnt_next = rstCnt_reg + 6'h1;
			end
			lblhr_pkg::BUS_IDLE:
			begin
				if (holdIn)
				begin
					state_next = lblhr_pkg::BUS_HOLD;
					grant_next = 1'b1;
				end
				else if (reqValid)
				begin
					state_next = lblhr_pkg::BUS_ADDR;
					addr_next = reqAddr;
					write_next = reqWrite;
					cache_next = reqCacheable && !reqSync;
					burst_next = reqBurst;
					word_next = 2'h0;
					lanesAll_next = reqLanes;
					wrData_next = reqWrData;
					strobe_next = 1'b1;
					lanesOut_next = laneSel(reqLanes, 2'h0);
					dataOut_next = {reqAddr[DATA_W-1:2], reqBurst};
				end
			end
			lblhr_pkg::BUS_ADDR:
			begin
				state_next = lblhr_pkg::BUS_DATA;
				dataOut_next = wrData_reg[0 +: DATA_W];
				if (burst_reg != 2'h0)
					lanesOut_next = laneSel(lanesAll_reg, 2'h1);
			end
			lblhr_pkg::BUS_DATA, lblhr_pkg::BUS_WAIT:
			begin
				if (readyIn && bufInReady)
				begin
					bufInValid = !write_reg;
					if (word_reg == burst_reg)
						state_next = lblhr_pkg::BUS_CHECK;
					else
					begin
						word_next = word_reg + 2'h1;
						state_next = lblhr_pkg::BUS_DATA;
						strobe_next = 1'b1;
						dataOut_next = wrData_reg[(word_reg + 2'h1)*DATA_W +: DATA_W];
						if (word_reg + 2'h1 < burst_reg)
							lanesOut_next = laneSel(lanesAll_reg, word_reg + 2'h2);
					end
				end
				else
					state_next = lblhr_pkg::BUS_WAIT; // lanes unchanged
			end
			lblhr_pkg::BUS_CHECK:
			begin
				error_next = errIn;
				done_next = 1'b1;
				lanesOut_next = lblhr_pkg::LANES_IDLE_N;
				state_next = holdIn ? lblhr_pkg::BUS_HOLD : lblhr_pkg::BUS_IDLE;
				grant_next = holdIn;
			end
			lblhr_pkg::BUS_HOLD:
			begin
				if (!holdIn)
				begin
					grant_next = 1'b0;
					state_next = lblhr_pkg::BUS_IDLE;
				end
			end
			default:
				state_next = lblhr_pkg::BUS_RESET;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			state_reg <= lblhr_pkg::BUS_RESET;
			addr_reg <= '0;
			write_reg <= 1'b0;
			cache_reg <= 1'b0;
			burst_reg <= 2'h0;
			word_reg <= 2'h0;
			lanesAll_reg <= '0;
			wrData_reg <= '0;
			lanesOut_reg <= lblhr_pkg::LANES_IDLE_N;
			dataOut_reg <= '0;
			strobe_reg <= 1'b0;
			grant_reg <= 1'b0;
			error_reg <= 1'b0;
			done_reg <= 1'b0;
			rstCnt_reg <= 6'h0;
		end
		else if (clkEn)
		begin
			state_reg <= state_next;
			addr_reg <= addr_next;
			write_reg <= write_next;
			cache_reg <= cache_next;
			burst_reg <= burst_next;
			word_reg <= word_next;
			lanesAll_reg <= lanesAll_next;
			wrData_reg <= wrData_next;
			lanesOut_reg <= lanesOut_next;
			dataOut_reg <= dataOut_next;
			strobe_reg <= strobe_next;
			grant_reg <= grant_next;
			error_reg <= error_next;
			done_reg <= done_next;
			rstCnt_reg <= rstCnt_next;
		end
	end

	// role strap tracked through reset
	always_ff @(posedge clk_sys)
	begin
		if (clkEn)
			role_reg <= (state_reg == lblhr_pkg::BUS_RESET) ? errIn : role_next;
	end
	assign initRole = role_reg;

	lblhr_skid_buf #(
		.WIDTH(DATA_W),
		.DEPTH(lblhr_pkg::BUF_DEPTH)
	) lblhr_skid_buf_inst (
		.clk_sys(clk_sys),
		.srst(srst),
		.clkEn(clkEn),
		.inValid(bufInValid),
		.inReady(bufInReady),
		.inData(bufInData),
		.outValid(rdValid),
		.outReady(rdReady),
		.outData(rdData)
	);

	// pin drive; bus lines float in reset and hold, grant ack floats in reset only
	logic busActive;
	assign busActive = (state_reg == lblhr_pkg::BUS_ADDR) || (state_reg == lblhr_pkg::BUS_DATA)
		|| (state_reg == lblhr_pkg::BUS_WAIT);
	assign localAddrDataOut = dataOut_reg;
	assign localAddrDataOe = (state_reg == lblhr_pkg::BUS_ADDR) || (busActive && write_reg);
	assign addressStrobeN = ~strobe_reg;
	assign addressStrobeOe = strobe_reg;
	assign writeNotRead = write_reg;
	assign byteLaneEnablesN = lanesOut_reg;
	assign byteLaneEnablesOe = busActive && (lanesOut_reg != lblhr_pkg::LANES_IDLE_N);
	assign cacheable = cache_reg && (state_reg == lblhr_pkg::BUS_ADDR);
	assign cacheableOe = busActive;
	assign busGrantAck = grant_reg;
	assign busGrantAckOe = (state_reg != lblhr_pkg::BUS_RESET);
	assign doneValid = done_reg;
	assign doneError = error_reg;
endmodule : lblhr_bus_ctrl
`default_nettype wire

// ---- sim/lblhr_bus_ctrl_chk.sv ----
// assertions on the lane, hold and reset pins
`timescale 1ns/1ps
`default_nettype none
module lblhr_bus_ctrl_chk (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic reqValid,
	input wire logic reqReady,
	input wire logic [1:0] reqBurst,
	input wire logic reqCacheable,
	input wire logic reqSync,
	input wire logic [15:0] reqLanes,
	input wire logic [31:0] localAddrDataOut,
	input wire logic localAddrDataOe,
	input wire logic addressStrobeN,
	input wire logic [3:0] byteLaneEnablesN,
	input wire logic byteLaneEnablesOe,
	input wire logic cacheable,
	input wire logic cacheableOe,
	input wire logic readyN,
	input wire logic holdReq,
	input wire logic busGrantAck
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	logic [3:0] rdyHist;
	logic take;
	logic calm;
	assign take = reqValid && reqReady;
	assign calm = readyN && (&rdyHist) && byteLaneEnablesOe;
	// lanes expected for the second word; illegal groups become all lanes
	logic [3:0] nextLanes;
	assign nextLanes = (reqLanes[7:4] inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hC, 4'h7, 4'hE,
		4'hF}) ? ~reqLanes[7:4] : 4'h0;
	always_ff @(posedge clk_sys)
		rdyHist <= srst ? 4'h0 : {rdyHist[2:0], readyN};
	reset_quiet_a: assert property ($past(srst) |-> !cacheableOe && !busGrantAck
		&& !localAddrDataOe && addressStrobeN && byteLaneEnablesN == 4'hF)
		else $error("outputs active after reset");
	lanes_contig_a: assert property (byteLaneEnablesOe |-> (~byteLaneEnablesN) inside
		{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hC, 4'h7, 4'hE, 4'hF}) else $error("lanes split");
	burst_size_a: assert property (take |=> !addressStrobeN && localAddrDataOe
		&& localAddrDataOut[1:0] == $past(reqBurst)) else $error("size bits wrong");
	first_lanes_a: assert property (take |=> byteLaneEnablesN == ~$past(reqLanes[3:0]))
		else $error("first lanes wrong");
	next_lanes_a: assert property (take && reqBurst != 2'h0 |=> ##1 byteLaneEnablesN == $past(nextLanes, 2))
		else $error("next word lanes wrong");
	cache_addr_a: assert property (take && reqCacheable && !reqSync |=> cacheable && cacheableOe)
		else $error("cacheable missing");
	cache_sync_a: assert property (take && reqSync |=> !cacheable)
		else $error("sync marked cacheable");
	lanes_hold_a: assert property (calm && $past(byteLaneEnablesOe) && $past(addressStrobeN)
		|-> $stable(byteLaneEnablesN)) else $error("lanes moved without ready");
	no_strobe_a: assert property (calm && $past(byteLaneEnablesOe) && $past(addressStrobeN)
		|-> addressStrobeN) else $error("strobe in wait");
	grant_float_a: assert property (busGrantAck |-> !localAddrDataOe && !byteLaneEnablesOe
		&& !cacheableOe) else $error("bus driven while granted");
	grant_drop_a: assert property (!holdReq [*4] |-> !busGrantAck)
		else $error("grant kept");
endmodule : lblhr_bus_ctrl_chk
bind lblhr_bus_ctrl lblhr_bus_ctrl_chk lblhr_bus_ctrl_chk_inst (.*);
`default_nettype wire

// ---- sim/lblhr_bus_agent.sv ----
// bus agent model answering each word with ready
`timescale 1ns/1ps
`default_nettype none
module lblhr_bus_agent (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic strap,
	input wire logic errWant,
	input wire logic [31:0] base,
	input wire logic addressStrobeN,
	input wire logic [31:0] localAddrDataOut,
	input wire logic [3:0] byteLaneEnablesN,
	output logic readyN,
	output logic accessErrorIn,
	output logic [31:0] localAddrDataIn
);
	int left;
	int dly;
	int boot;
	logic [31:0] idx;
	logic errSlot;
	logic [1:0] lowAddr;
	assign localAddrDataIn = base + idx;
	// low byte address decoded from the lowest active lane
	always_comb
	begin
		lowAddr = 2'h3;
		for (int i = 3; i >= 0; i--)
			if (!byteLaneEnablesN[i])
				lowAddr = 2'(i);
	end
	always @(posedge clk_sys)
	begin
		readyN <= 1'b1;
		errSlot <= 1'b0;
		boot <= srst ? 30 : (boot > 0 ? boot - 1 : 0);
		accessErrorIn <= boot > 0 ? strap : errSlot && errWant;
		if (srst)
			left <= 0;
		else if (left == 0 && !addressStrobeN)
		begin
			left <= localAddrDataOut[1:0] + 1;
			dly <= base[2:0] + 5 + lowAddr; // lanes read only in address state
			idx <= 32'hFFFFFFFF;
		end
		else if (left > 0 && dly == 0)
		begin
			readyN <= 1'b0; // wait states until here
			errSlot <= left == 1;
			left <= left - 1;
			dly <= base[2:0] + 5;
		end
		else if (left > 0)
		begin
			dly <= dly - 1;
			if (dly == 1)
				idx <= idx + 1;
		end
	end
endmodule : lblhr_bus_agent
`default_nettype wire

// ---- sim/local_bus_lanes_hold_reset_tb_top.sv ----
// testbench for the local bus lane, hold and reset block
`timescale 1ns/1ps
`default_nettype none
module local_bus_lanes_hold_reset_tb_top;
	logic clk_sys, srst, clkEn, reqValid, reqReady, reqWrite, reqCacheable, reqSync, rdValid;
	logic rdReady, doneValid, doneError, initRole, internalClk, localAddrDataOe, addressStrobeN;
	logic addressStrobeOe, writeNotRead, byteLaneEnablesOe, cacheable, cacheableOe, readyN;
	logic holdReq, busGrantAck, busGrantAckOe, accessErrorIn, strap, errWant, stall, holdMid;
	logic [1:0] reqBurst;
	logic [3:0] byteLaneEnablesN;
	logic [15:0] reqLanes;
	logic [127:0] reqWrData;
	logic [31:0] reqAddr, rdData, localAddrDataIn, localAddrDataOut, base;
	logic [63:0] e;
	logic [63:0] rdQ[$];
	logic [31:0] wrQ[$];
	logic doneQ[$];
	logic [3:0] legal[10] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hC, 4'h7, 4'hE, 4'hF};
	integer seed;
	int mismatches, cmp_count, cycles;
	lblhr_bus_ctrl lblhr_bus_ctrl_inst (.*);
	lblhr_bus_agent lblhr_bus_agent_inst (.*);
	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) rdReady <= #1 (stall ? 1'b0 : (($random(seed) & 3) != 0));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic tally_and_finish();
		mismatches += rdQ.size() + doneQ.size() + wrQ.size();
		if (mismatches == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			tally_and_finish();
		end
		if (!srst && rdValid === 1'b1 && rdReady)
		begin
			e = rdQ.size() ? rdQ.pop_front() : 64'h1;
			chk("read data", e[31:0], rdData & e[63:32]);
		end
		if (!srst && readyN === 1'b0 && writeNotRead === 1'b1)
		begin
			chk("write data", wrQ.size() ? wrQ.pop_front() : 32'hX, localAddrDataOut);
			chk("write drive", 32'h1, localAddrDataOe);
		end
		if (!srst && doneValid === 1'b1)
			chk("done error", doneQ.size() ? doneQ.pop_front() : 1'bx, doneError);
	end
	task automatic txn(input logic wr, input logic [1:0] bl, input logic bad, input logic st);
		logic [3:0] ln[4];
		logic [3:0] m;
		logic [31:0] bm;
		for (int i = 0; i < 4; i++)
			ln[i] = legal[$unsigned($random(seed)) % 10];
		if (bad)
			ln[bl] = 4'h5;
		stall = st;
		// read buffer drained first: a full buffer would swallow a ready
		while (rdValid === 1'b1) @(posedge clk_sys) #1;
		reqWrite = wr;
		reqBurst = bl;
		base = $random(seed);
		errWant = $random(seed);
		reqCacheable = $random(seed);
		reqSync = $random(seed);
		reqAddr = $random(seed);
		reqWrData = {$random(seed), $random(seed), $random(seed), $random(seed)};
		reqLanes = {ln[3], ln[2], ln[1], ln[0]};
		reqValid = 1'b1;
		while (reqReady !== 1'b1) @(posedge clk_sys) #1;
		@(posedge clk_sys) #1;
		reqValid = 1'b0;
		holdReq = holdMid;
		doneQ.push_back(errWant);
		for (int i = 0; i <= bl; i++)
		begin
			m = bad && i == bl ? 4'hF : ln[i];
			bm = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
			if (!wr)
				rdQ.push_back({bm, (base + i) & bm});
			else
				wrQ.push_back(reqWrData[32*i +: 32]);
		end
		while (doneValid !== 1'b1) @(posedge clk_sys) #1;
	endtask : txn
	task automatic hold_cycle();
		holdReq = 1'b1; // kept while the bus is wanted
		repeat (8) @(posedge clk_sys) #1;
		chk("grant", 1, busGrantAck);
		chk("ready while held", 0, reqReady);
		holdReq = 1'b0;
		repeat (5) @(posedge clk_sys) #1;
		chk("grant released", 0, busGrantAck);
	endtask : hold_cycle
	initial
	begin
		seed = 32'h33E53688;
		clk_sys = 1'b0;
		clkEn = 1'b1;
		{reqValid, reqWrite, reqCacheable, reqSync, holdReq, errWant, stall, holdMid} = '0;
		{reqBurst, reqLanes, reqWrData, reqAddr, base} = '0;
		for (int r = 0; r < 2; r++)
		begin
			strap = r == 0;
			srst = 1'b1;
			repeat (4) @(posedge clk_sys) #1;
			srst = 1'b0; // released just after an edge; settle count covers length
			for (int k = 0; k < 12; k++)
				txn(1'($random(seed)) & (k != 5), 2'(k), k % 4 != 0 && k[2], k == 5);
			chk("init role", strap, initRole);
			holdMid = 1'b1;
			txn(1'b0, 2'h3, 1'b0, 1'b0);
			holdMid = 1'b0;
			hold_cycle();
		end
		tally_and_finish();
	end
endmodule : local_bus_lanes_hold_reset_tb_top
`default_nettype wire
